//--- hw/pcs_pkg.sv
package pcs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// peripheral indices and widths
	localparam int unsigned NUM_PERIPH = 8;
	localparam int unsigned TPS_W = 4;
	localparam int unsigned P_T0 = 0;
	localparam int unsigned P_T1 = 1;
	localparam int unsigned P_T2 = 2;
	localparam int unsigned P_PCA = 3;
	localparam int unsigned P_WDT = 4;
	localparam int unsigned P_UART = 5;
	localparam int unsigned P_TWI = 6;
	localparam int unsigned P_SPI = 7;
	// peripherals served by the timer prescaler (counter array decided at run time)
	localparam logic [NUM_PERIPH-1:0] PRESCALED_MASK = 8'h1F;

	////////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [9:0] CTRL0_IDX = 10'h08F;
	localparam logic [9:0] CTRL1_IDX = 10'h0AF;
	localparam logic [9:0] STATUS_IDX = 10'h090;
	localparam int unsigned ADDR_LSB = 2;
	localparam int unsigned ADDR_MSB = 11;
	localparam logic [7:0] CTRL0_RESET = 8'h00;
	localparam logic CTRL1_SPI_RESET = 1'h0;

	// control 0 field positions
	localparam int unsigned B_X2 = 0;
	localparam int unsigned B_T0 = 1;
	localparam int unsigned B_T1 = 2;
	localparam int unsigned B_T2 = 3;
	localparam int unsigned B_UART = 4;
	localparam int unsigned B_PCA = 5;
	localparam int unsigned B_WDT = 6;
	localparam int unsigned B_TWI = 7;
	// control 1 field position
	localparam int unsigned B_SPI = 0;
	// status field positions
	localparam int unsigned S_CNT_LSB = 0;
	localparam int unsigned S_COMPAT = 4;
	localparam int unsigned S_SRC01 = 5;
	localparam int unsigned S_FUSE_DONE = 6;

	////////////////////////////////////////////////////////////////////////////
	// timing and encodings
	localparam logic [1:0] CPS_SYSCLK = 2'h1;
	localparam logic [3:0] MC_COMPAT_X1 = 4'hC;
	localparam logic [3:0] MC_COMPAT_X2 = 4'h6;
	localparam logic [3:0] MC_FAST_X1 = 4'h2;
	localparam logic [3:0] MC_FAST_X2 = 4'h1;
	// prescale defaults, loaded by the outside prescale register
	localparam logic [3:0] TPS_DEFAULT_FAST = 4'h0;
	localparam logic [3:0] TPS_DEFAULT_COMPAT = 4'h5;
	localparam logic HRESP_OKAY = 1'h0;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} pcs_ahb_in_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} pcs_ahb_out_t;

	typedef struct packed {
		logic compat;
		logic [TPS_W-1:0] timer_prescale_value;
		logic [1:0] counter_array_source_field;
	} pcs_clk_cfg_t;

	typedef struct packed {
		logic fuse_loaded;
		logic [7:0] ctrl0;
		logic ctrl1_spi;
		logic dph_wr;
		logic [9:0] dph_idx;
		logic [31:0] rdata;
		logic [3:0] mc_cnt;
	} pcs_top_st_t;

	typedef struct packed {
		logic [TPS_W-1:0] cnt;
	} pcs_pre_st_t;

	typedef struct packed {
		logic tog;
	} pcs_div_st_t;

endpackage : pcs_pkg

//--- hw/pcs_prescaler.sv
`timescale 1ns/1ps
module pcs_prescaler
	import pcs_pkg::*;
#(
	parameter int unsigned W = TPS_W
)(
	input wire logic clk_i, // cpu clock
	input wire logic rst_n_i, // synchronised reset, active low
	input wire logic ce_i, // cpu cycle enable
	input wire logic [W-1:0] tps_i, // stored prescale value
	output logic tick_o, // one-cycle prescaled pulse
	output logic [W-1:0] count_o // live counter value
);

	pcs_pre_st_t st_r;
	pcs_pre_st_t st_nxt;

	////////////////////////////////////////////////////////////////////////////
	// down count, reload
	always_comb begin
		st_nxt = st_r;
		if (ce_i) begin
			if (st_r.cnt == '0) begin
				st_nxt.cnt = tps_i;
			end else begin
				st_nxt.cnt = st_r.cnt - 1'h1;
			end
		end
	end

	// state freezes with the cpu cycle enable
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_o = ce_i & (st_r.cnt == '0);
	assign count_o = st_r.cnt;

	////////////////////////////////////////////////////////////////////////////
	property p_reload;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && st_r.cnt == '0) |=> (st_r.cnt == $past(tps_i));
	endproperty
	a_reload: assert property (p_reload) else $error("prescaler missed reload");

endmodule : pcs_prescaler

//--- hw/pcs_periph_div.sv
`timescale 1ns/1ps
module pcs_periph_div
	import pcs_pkg::*;
(
	input wire logic clk_i, // cpu clock
	input wire logic rst_n_i, // synchronised reset, active low
	input wire logic base_i, // base tick, already ce-gated
	input wire logic halve_i, // add divide-by-two
	output logic tick_o // peripheral enable pulse
);

	pcs_div_st_t st_r;
	pcs_div_st_t st_nxt;

	////////////////////////////////////////////////////////////////////////////
	// toggle halves base
	always_comb begin
		st_nxt = st_r;
		if (!halve_i) begin
			st_nxt.tog = 1'h0; // restart phase so the first halved pulse waits one base tick
		end else if (base_i) begin
			st_nxt.tog = ~st_r.tog;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_o = base_i & (~halve_i | st_r.tog);

	////////////////////////////////////////////////////////////////////////////
	sequence s_halved_pass;
		halve_i && base_i && tick_o;
	endsequence
	sequence s_halved_skip;
		halve_i && base_i && !tick_o;
	endsequence
	property p_halve_pass;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_halved_pass |=> !st_r.tog;
	endproperty
	property p_halve_skip;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_halved_skip |=> (st_r.tog && (halve_i && base_i) |-> tick_o);
	endproperty
	a_halve_pass: assert property (p_halve_pass) else $error("halved pulse not followed by skip");
	a_halve_skip: assert property (p_halve_skip) else $error("halved skip not followed by pulse");

endmodule : pcs_periph_div

//--- hw/pcs_top.sv
`timescale 1ns/1ps
module pcs_top
	import pcs_pkg::*;
(
	input wire logic clk_i, // cpu clock, 10 MHz
	input wire logic resetn_i, // async reset, active low
	input wire logic ce_i, // cpu cycle enable, freezes all state when low
	input wire pcs_ahb_in_t ahb_i, // ahb-lite slave inputs
	output pcs_ahb_out_t ahb_o, // ahb-lite slave outputs
	input wire pcs_clk_cfg_t cfg_i, // mode, prescale value, counter array source
	input wire logic fuse_cpu_doubling_i, // fuse level for the doubling bit
	output logic [NUM_PERIPH-1:0] periph_ce_o, // per-peripheral enable pulses
	output logic machine_cycle_ce_o, // one pulse per machine cycle
	output logic cpu_clock_doubling_o // current doubling bit
);

	////////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic [1:0] rst_sync_r;
	logic rst_n;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'h1};
		end
	end

	assign rst_n = rst_sync_r[1];

	////////////////////////////////////////////////////////////////////////////
	// state
	pcs_top_st_t st_r;
	pcs_top_st_t st_nxt;

	logic addr_valid;
	logic addr_in_map;
	logic [9:0] addr_idx;
	logic pre_tick;
	logic [TPS_W-1:0] pre_count;
	logic x2;
	logic src_sysclk;
	logic [3:0] mc_len;
	logic [3:0] mc_len_m1;
	logic [NUM_PERIPH-1:0] sel;
	logic [NUM_PERIPH-1:0] uses_pre;
	logic [NUM_PERIPH-1:0] base;
	logic [NUM_PERIPH-1:0] halve;

	////////////////////////////////////////////////////////////////////////////
	// bus address phase decode
	assign addr_valid = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1];
	assign addr_in_map = ~|ahb_i.haddr[31:ADDR_MSB+1];
	assign addr_idx = ahb_i.haddr[ADDR_MSB:ADDR_LSB];

	// read mux sees the registers as they will stand after this edge, the prescale count as it stands now
	function automatic logic [31:0] read_mux(input logic [9:0] idx, input pcs_top_st_t s,
			input logic [TPS_W-1:0] cnt, input logic compat, input logic srcsys);
		logic [31:0] d;
		d = 32'h0;
		if (idx == CTRL0_IDX) begin
			d[7:0] = s.ctrl0;
		end else if (idx == CTRL1_IDX) begin
			d[B_SPI] = s.ctrl1_spi; // undefined bits read as zero
		end else if (idx == STATUS_IDX) begin
			d[S_CNT_LSB +: TPS_W] = cnt;
			d[S_COMPAT] = compat;
			d[S_SRC01] = srcsys;
			d[S_FUSE_DONE] = s.fuse_loaded;
		end else begin
			d = 32'h0; // unmapped reads zero, answer stays okay
		end
		return d;
	endfunction : read_mux

	////////////////////////////////////////////////////////////////////////////
	// ce_i is the shaped cpu clock
	pcs_prescaler #(
		.W(TPS_W)
	) u_pre (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.ce_i(ce_i),
		.tps_i(cfg_i.timer_prescale_value),
		.tick_o(pre_tick),
		.count_o(pre_count)
	);

	////////////////////////////////////////////////////////////////////////////
	// machine cycle length
	assign x2 = st_r.ctrl0[B_X2];
	always_comb begin
		if (cfg_i.compat) begin
			mc_len = x2 ? MC_COMPAT_X2 : MC_COMPAT_X1;
		end else begin
			mc_len = x2 ? MC_FAST_X2 : MC_FAST_X1;
		end
	end
	assign mc_len_m1 = mc_len - 4'h1;

	////////////////////////////////////////////////////////////////////////////
	// next-state: fuse load, register writes, bus phase, cycle counter
	always_comb begin
		st_nxt = st_r;
		if (ce_i) begin
			if (!st_r.fuse_loaded) begin
				st_nxt.fuse_loaded = 1'h1;
				st_nxt.ctrl0[B_X2] = fuse_cpu_doubling_i;
			end
			// data phase of a write completes here, since hreadyout follows ce
			if (st_r.dph_wr) begin
				if (st_r.dph_idx == CTRL0_IDX) begin
					st_nxt.ctrl0 = ahb_i.hwdata[7:0];
				end else if (st_r.dph_idx == CTRL1_IDX) begin
					st_nxt.ctrl1_spi = ahb_i.hwdata[B_SPI];
				end
			end
			// capture the next address phase
			st_nxt.dph_wr = addr_valid & ahb_i.hwrite & addr_in_map;
			st_nxt.dph_idx = addr_idx;
			if (addr_valid & ~ahb_i.hwrite) begin
				st_nxt.rdata = addr_in_map ?
					read_mux(addr_idx, st_nxt, pre_count, cfg_i.compat, src_sysclk) : 32'h0;
			end
			if (st_r.mc_cnt == 4'h0) begin
				st_nxt.mc_cnt = mc_len_m1;
			end else if (st_r.mc_cnt > mc_len_m1) begin
				st_nxt.mc_cnt = mc_len_m1; // shortened cycle after a mode change
			end else begin
				st_nxt.mc_cnt = st_r.mc_cnt - 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r.fuse_loaded <= 1'h0;
			st_r.ctrl0 <= CTRL0_RESET;
			st_r.ctrl1_spi <= CTRL1_SPI_RESET;
			st_r.dph_wr <= 1'h0;
			st_r.dph_idx <= 10'h000;
			st_r.rdata <= 32'h0;
			st_r.mc_cnt <= 4'h0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus answers: zero wait, stalled only while the cpu cycle is frozen
	assign ahb_o.hrdata = st_r.rdata;
	assign ahb_o.hreadyout = ce_i;
	assign ahb_o.hresp = HRESP_OKAY;

	assign cpu_clock_doubling_o = x2;
	assign machine_cycle_ce_o = ce_i & (st_r.mc_cnt == 4'h0);

	////////////////////////////////////////////////////////////////////////////
	// select bits gathered per peripheral index
	assign sel[P_T0] = st_r.ctrl0[B_T0];
	assign sel[P_T1] = st_r.ctrl0[B_T1];
	assign sel[P_T2] = st_r.ctrl0[B_T2];
	assign sel[P_PCA] = st_r.ctrl0[B_PCA];
	assign sel[P_WDT] = st_r.ctrl0[B_WDT];
	assign sel[P_UART] = st_r.ctrl0[B_UART];
	assign sel[P_TWI] = st_r.ctrl0[B_TWI];
	assign sel[P_SPI] = st_r.ctrl1_spi;

	assign src_sysclk = (cfg_i.counter_array_source_field == CPS_SYSCLK);
	assign uses_pre = src_sysclk ? (PRESCALED_MASK & ~(8'h01 << P_PCA)) : PRESCALED_MASK;

	////////////////////////////////////////////////////////////////////////////
	// per-peripheral rate selection
	// the doubled compatibility setting of unprescaled peripherals is ignored
	// without cpu doubling, so they can never run slower than the cpu intends
	// one pulse per peripheral
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_per
			// timers and watchdog share the prescaled path
			assign base[gi] = cfg_i.compat ? (uses_pre[gi] ? pre_tick : ce_i)
				: (sel[gi] ? pre_tick : ce_i);
			assign halve[gi] = cfg_i.compat & sel[gi] & (uses_pre[gi] | x2);

			pcs_periph_div u_div (
				.clk_i(clk_i),
				.rst_n_i(rst_n),
				.base_i(base[gi] & ce_i),
				.halve_i(halve[gi]),
				.tick_o(periph_ce_o[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	property p_fast_bypass;
		(!cfg_i.compat && !sel[P_T0] && ce_i) |-> periph_ce_o[P_T0];
	endproperty
	a_fast_bypass: assert property (p_fast_bypass) else $error("fast mode bypass lost a pulse");

	property p_fast_apply;
		(!cfg_i.compat && sel[P_T1]) |-> (periph_ce_o[P_T1] == pre_tick);
	endproperty
	a_fast_apply: assert property (p_fast_apply) else $error("fast mode prescaler not applied");

	property p_compat_plain;
		(cfg_i.compat && !sel[P_T2]) |-> (periph_ce_o[P_T2] == pre_tick);
	endproperty
	a_compat_plain: assert property (p_compat_plain) else $error("timer 2 not at prescale rate");

	property p_wdt_double;
		(cfg_i.compat && sel[P_WDT] && periph_ce_o[P_WDT]) |-> pre_tick;
	endproperty
	a_wdt_double: assert property (p_wdt_double) else $error("watchdog pulse off prescaler");

	property p_twi_guard;
		(cfg_i.compat && !x2 && ce_i) |-> periph_ce_o[P_TWI];
	endproperty
	a_twi_guard: assert property (p_twi_guard) else $error("two-wire halved without doubling");

	property p_uart_guard;
		(cfg_i.compat && !x2 && ce_i) |-> periph_ce_o[P_UART];
	endproperty
	a_uart_guard: assert property (p_uart_guard) else $error("uart halved without doubling");

	property p_spi_guard;
		(cfg_i.compat && !x2 && ce_i) |-> periph_ce_o[P_SPI];
	endproperty
	a_spi_guard: assert property (p_spi_guard) else $error("spi halved without doubling");

	property p_pca_src01;
		(cfg_i.compat && src_sysclk && !sel[P_PCA]) |-> (periph_ce_o[P_PCA] == ce_i);
	endproperty
	a_pca_src01: assert property (p_pca_src01) else $error("counter array not at cpu rate");

	sequence s_mc_pulse;
		machine_cycle_ce_o && (st_r.mc_cnt == 4'h0);
	endsequence
	property p_mc_len;
		s_mc_pulse |=> (st_r.mc_cnt == $past(mc_len_m1));
	endproperty
	a_mc_len: assert property (p_mc_len) else $error("machine cycle length wrong");

	property p_ctrl_reset;
		!st_r.fuse_loaded |-> (st_r.ctrl0 == CTRL0_RESET && st_r.ctrl1_spi == CTRL1_SPI_RESET);
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset value wrong");

	property p_fuse_load;
		(!st_r.fuse_loaded && ce_i) |=> (cpu_clock_doubling_o == $past(fuse_cpu_doubling_i));
	endproperty
	a_fuse_load: assert property (p_fuse_load) else $error("doubling bit not taken from fuse");

	////////////////////////////////////////////////////////////////////////////
	// further checks on frozen cycles, register writes and per-peripheral rates
	property p_no_pulse_frozen;
		!ce_i |-> (periph_ce_o == '0 && !machine_cycle_ce_o);
	endproperty
	a_no_pulse_frozen: assert property (p_no_pulse_frozen) else $error("pulse while cpu cycle frozen");

	property p_state_frozen;
		!ce_i |=> $stable(st_r);
	endproperty
	a_state_frozen: assert property (p_state_frozen) else $error("state moved while frozen");

	property p_wr_ctrl0;
		(ce_i && st_r.dph_wr && st_r.dph_idx == CTRL0_IDX) |=> (st_r.ctrl0 == $past(ahb_i.hwdata[7:0]));
	endproperty
	a_wr_ctrl0: assert property (p_wr_ctrl0) else $error("control 0 write lost");

	property p_wr_ctrl1;
		(ce_i && st_r.dph_wr && st_r.dph_idx == CTRL1_IDX) |=> (st_r.ctrl1_spi == $past(ahb_i.hwdata[B_SPI]));
	endproperty
	a_wr_ctrl1: assert property (p_wr_ctrl1) else $error("control 1 write lost");

	property p_compat_t0_plain;
		(cfg_i.compat && !sel[P_T0]) |-> (periph_ce_o[P_T0] == pre_tick);
	endproperty
	a_compat_t0_plain: assert property (p_compat_t0_plain) else $error("timer 0 not at prescale rate");

	property p_compat_t1_plain;
		(cfg_i.compat && !sel[P_T1]) |-> (periph_ce_o[P_T1] == pre_tick);
	endproperty
	a_compat_t1_plain: assert property (p_compat_t1_plain) else $error("timer 1 not at prescale rate");

	property p_wdt_plain;
		(cfg_i.compat && !sel[P_WDT]) |-> (periph_ce_o[P_WDT] == pre_tick);
	endproperty
	a_wdt_plain: assert property (p_wdt_plain) else $error("watchdog not at prescale rate");

	property p_pca_src00_plain;
		(cfg_i.compat && !src_sysclk && !sel[P_PCA]) |-> (periph_ce_o[P_PCA] == pre_tick);
	endproperty
	a_pca_src00_plain: assert property (p_pca_src00_plain) else $error("counter array off prescaler");

	property p_t2_double;
		(cfg_i.compat && sel[P_T2] && periph_ce_o[P_T2]) |-> pre_tick;
	endproperty
	a_t2_double: assert property (p_t2_double) else $error("timer 2 pulse off prescaler");

	property p_fast_twi_apply;
		(!cfg_i.compat && sel[P_TWI]) |-> (periph_ce_o[P_TWI] == pre_tick);
	endproperty
	a_fast_twi_apply: assert property (p_fast_twi_apply) else $error("two-wire prescaler not applied");

	property p_fast_uart_bypass;
		(!cfg_i.compat && !sel[P_UART]) |-> (periph_ce_o[P_UART] == ce_i);
	endproperty
	a_fast_uart_bypass: assert property (p_fast_uart_bypass) else $error("uart bypass lost a pulse");

	property p_fast_spi_apply;
		(!cfg_i.compat && sel[P_SPI]) |-> (periph_ce_o[P_SPI] == pre_tick);
	endproperty
	a_fast_spi_apply: assert property (p_fast_spi_apply) else $error("spi prescaler not applied");

	sequence s_spi_halved_pulse;
		cfg_i.compat && x2 && sel[P_SPI] && periph_ce_o[P_SPI];
	endsequence
	property p_spi_halved_skip;
		s_spi_halved_pulse |=> (!periph_ce_o[P_SPI] || !halve[P_SPI]);
	endproperty
	a_spi_halved_skip: assert property (p_spi_halved_skip) else $error("spi halving did not skip");

	property p_mc_in_cycle;
		machine_cycle_ce_o |-> ce_i;
	endproperty
	a_mc_in_cycle: assert property (p_mc_in_cycle) else $error("machine cycle pulse while frozen");

	property p_pca_src01_halve;
		(cfg_i.compat && src_sysclk && sel[P_PCA] && !x2) |-> (periph_ce_o[P_PCA] == ce_i);
	endproperty
	a_pca_src01_halve: assert property (p_pca_src01_halve) else $error("counter array halved without doubling");

endmodule : pcs_top

//--- bench/pcs_top_tb.sv
`timescale 1ns/1ps
`define CHK(G, E) begin checked++; if ((G) !== (E)) begin failures++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (G), (E)); end end

module pcs_top_tb;
	import pcs_pkg::*;

	localparam int unsigned TIMEOUT_CYC = 80000;
	logic clk_i, resetn_i, ce_i, fuse_i, dbl, mc_ce;
	pcs_ahb_in_t bus, ahb_in;
	pcs_ahb_out_t ahb_o;
	pcs_clk_cfg_t cfg;
	logic [NUM_PERIPH-1:0] periph_ce;
	logic [8:0] pulses;
	logic [31:0] exp_q[$];
	logic rd_dp, meas_on, have_last, ce_rand, c1;
	logic [7:0] c0;
	int failures, checked, cyc, mbit, since;

	pcs_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .ahb_i(ahb_in), .ahb_o(ahb_o),
		.cfg_i(cfg), .fuse_cpu_doubling_i(fuse_i), .periph_ce_o(periph_ce),
		.machine_cycle_ce_o(mc_ce), .cpu_clock_doubling_o(dbl));

	// single slave, so its ready is the bus ready
	always_comb begin
		ahb_in = bus;
		ahb_in.hready = ahb_o.hreadyout;
	end
	assign pulses = {mc_ce, periph_ce};

	// 10 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// random cpu cycle enable shakes both bus stalls and the freezing of all counts
	always @(posedge clk_i) begin
		ce_i <= ce_rand ? ($urandom_range(3) != 0) : 1'b1;
	end

	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc >= TIMEOUT_CYC) begin
			failures++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result watcher: read data and pulse spacing (in enabled cycles), oldest note first
	always @(posedge clk_i) begin
		logic [31:0] e;
		if (rd_dp === 1'b1 && ahb_o.hreadyout === 1'b1) begin
			rd_dp = 1'b0;
			e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
			`CHK(ahb_o.hrdata, e)
			`CHK(ahb_o.hresp, HRESP_OKAY)
		end
		if (ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready && !ahb_in.hwrite) begin
			rd_dp = 1'b1;
		end
		if (!meas_on) begin
			have_last = 1'b0;
			since = 0;
		end else begin
			if (ce_i === 1'b1) since++;
			if (pulses[mbit] !== 1'b0) begin
				if (have_last && exp_q.size() != 0) begin
					e = exp_q.pop_front();
					`CHK(32'(since), e)
				end
				have_last = 1'b1;
				since = 0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// one whole-word transfer; the request is held until hready is seen high
	task automatic bus_xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
		input logic [31:0] ex);
		if (!wr) exp_q.push_back(ex);
		bus.hsel <= 1'b1;
		bus.haddr <= 32'({idx, 2'h0});
		bus.htrans <= 2'h2;
		bus.hwrite <= wr;
		bus.hsize <= 3'h2;
		// only the bench timeout ends a wait
		do begin
			@(posedge clk_i);
		end while (ahb_o.hreadyout !== 1'b1);
		bus.htrans <= 2'h0;
		bus.hsel <= 1'b0;
		bus.hwdata <= wd;
		do begin
			@(posedge clk_i);
		end while (ahb_o.hreadyout !== 1'b1);
	endtask : bus_xfer

	task automatic do_reset(input logic fuse);
		ce_rand = 1'b0;
		resetn_i <= 1'b0;
		fuse_i <= fuse;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask : do_reset

	// expected spacing of pulses, in enabled cycles
	function automatic int exp_per(input int b);
		int pos[7] = '{B_T0, B_T1, B_T2, B_PCA, B_WDT, B_UART, B_TWI};
		logic s;
		logic unpre;
		int pre;
		pre = int'(cfg.timer_prescale_value) + 1;
		if (b == 8) return cfg.compat ? (c0[B_X2] ? 6 : 12) : (c0[B_X2] ? 1 : 2);
		s = (b == P_SPI) ? c1 : c0[pos[b]];
		unpre = (b == P_UART) || (b == P_TWI) || (b == P_SPI) || (b == P_PCA && cfg.counter_array_source_field == CPS_SYSCLK);
		if (!cfg.compat) return s ? pre : 1;
		if (unpre) return (s && c0[B_X2]) ? 2 : 1;
		return s ? 2 * pre : pre;
	endfunction : exp_per

	// notes three spacings of one enable and waits until all are taken
	task automatic measure(input int b, input int per);
		@(negedge clk_i);
		mbit = b;
		repeat (3) exp_q.push_back(per);
		meas_on = 1'b1;
		while (exp_q.size() != 0) @(negedge clk_i);
		meas_on = 1'b0;
		@(posedge clk_i);
	endtask : measure

	task automatic test_done();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////////
	// main sequence: two resets with opposite fuse levels, each followed by a sweep
	initial begin
		resetn_i = 1'b0;
		ce_i = 1'b1;
		fuse_i = 1'b0;
		bus = '0;
		cfg = '0;
		failures = 0;
		checked = 0;
		cyc = 0;
		rd_dp = 1'b0;
		meas_on = 1'b0;
		have_last = 1'b0;
		since = 0;
		mbit = 0;
		ce_rand = 1'b0;
		c0 = '0;
		c1 = 1'b0;
		void'($urandom(32'h1EA9091C));
		@(posedge clk_i);
		for (int r = 0; r < 2; r++) begin
			do_reset(r[0]);
			bus_xfer(1'b0, CTRL0_IDX, '0, {31'h0, r[0]});
			bus_xfer(1'b0, CTRL1_IDX, '0, 32'h0);
			`CHK(dbl, r[0])
			ce_rand = 1'b1;
			// only the spi select is kept; unmapped space reads zero
			bus_xfer(1'b1, CTRL1_IDX, 32'hFFFFFFFF, '0);
			bus_xfer(1'b0, CTRL1_IDX, '0, 32'h1);
			bus_xfer(1'b1, 10'h001, 32'hFFFFFFFF, '0);
			bus_xfer(1'b0, 10'h001, '0, 32'h0);
			for (int k = 0; k < 8; k++) begin
				c0 = 8'($urandom());
				c1 = 1'($urandom());
				bus_xfer(1'b1, CTRL0_IDX, 32'(c0), '0);
				bus_xfer(1'b0, CTRL0_IDX, '0, 32'(c0));
				`CHK(dbl, c0[B_X2])
				bus_xfer(1'b1, CTRL1_IDX, 32'(c1), '0);
				cfg.compat <= k[0];
				cfg.counter_array_source_field <= k[2:1];
				cfg.timer_prescale_value <= (k == 1) ? 4'h0 : (k == 2) ? 4'hF : 4'($urandom());
				// let the prescaler reload and any halving settle
				repeat (80) @(posedge clk_i);
				for (int b = 0; b < 9; b++) measure(b, exp_per(b));
			end
		end
		test_done();
	end

endmodule : pcs_top_tb
